// ==== keyboard_scan_encoder.sv ====
// Scanning keyboard encoder: counter, decoder and sense multiplexer with hold timer,
// modifier remap, debounced function keys, lockout gating and an APB register slave.
// Assumes matrix, modifier and function-key pins are asynchronous to clk.
`include "kbd_scan_map.svh"

module keyboard_scan_encoder
    import kbd_scan_pkg::*;
#(
    parameter int SCAN_CYC = `KS_SCAN_CYC,
    parameter int HOLD_CYC = `KS_HOLD_CYC,
    parameter int DEB_CYC = `KS_DEB_CYC
) (
    // Clock, reset, enable
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Key matrix
    output logic [15:0] drive_lines,
    input wire logic [15:0] sense_lines,
    // Modifier and function keys
    input wire logic shift_key,
    input wire logic control_key,
    input wire logic interrupt_key_pin,
    input wire logic repeat_key_pin,
    input wire logic lockout_n,
    // Front-end side
    output logic [6:0] key_code,
    output logic key_code_valid_strobe,
    output logic interrupt_key_line,
    output logic repeat_key_line
);

    // Sense path needs about seven cycles to settle after the decoder moves
    if (SCAN_CYC < 12) begin : g_scan_chk
        $error("SCAN_CYC too small for the sense pipeline");
    end
    if (HOLD_CYC <= SCAN_CYC) begin : g_hold_chk
        $error("HOLD_CYC must exceed one scan period");
    end
    if (DEB_CYC < 2) begin : g_deb_chk
        $error("DEB_CYC must be at least 2");
    end

    localparam int DIV_W = $clog2(SCAN_CYC);
    localparam int HOLD_W = $clog2(HOLD_CYC + 1);
    localparam int DEB_W = $clog2(DEB_CYC);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCAN_CYC - 1);
    localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYC);
    localparam logic [DEB_W-1:0] DEB_LAST = DEB_W'(DEB_CYC - 1);
    localparam int NLINES = 21;

    logic [DIV_W-1:0] div_cnt;
    logic [DEB_W-1:0] deb_cnt;
    logic [7:0] scan_cnt;
    logic [HOLD_W-1:0] hold_cnt;
    logic [1:0] ctrl;
    key_state_t state, next_state;
    key_code_t code_reg;
    logic [NLINES-1:0] pin_vec, line_lvl;
    logic [15:0] sense_lvl;

    wire logic scan_tick = (div_cnt == DIV_LAST);
    wire logic deb_tick = (deb_cnt == DEB_LAST);
    wire logic scan_en = ctrl[`KS_CTRL_SCAN_EN];
    wire logic held = (hold_cnt != '0);
    wire logic intr_lvl = line_lvl[16];
    wire logic rpt_lvl = line_lvl[17];
    wire logic shift_lvl = line_lvl[18];
    wire logic ctl_lvl = line_lvl[19];
    wire logic lock_pin_lvl = line_lvl[20];
    wire logic outputs_ok = lock_pin_lvl && !ctrl[`KS_CTRL_LOCK];
    // Mux: upper counter bits pick the sense line
    wire logic mux_out = sense_lvl[scan_cnt[7:4]];
    wire logic match = scan_en && scan_tick && mux_out;
    wire logic advance = scan_en && scan_tick && !mux_out && !held && state == ST_SCAN;

    assign pin_vec = {lockout_n, control_key, shift_key, repeat_key_pin, interrupt_key_pin,
        sense_lines};
    assign sense_lvl = line_lvl[15:0];

    // Matrix and modifier lines pass undebounced; function keys use the slow tick
    genvar gi;
    for (gi = 0; gi < NLINES; gi++) begin : g_line
        key_line_filter u_filt (
            .clk(clk),
            .rstn(rstn),
            .ce(ce),
            .sample_tick((gi == 16 || gi == 17) ? deb_tick : 1'b1),
            .pin(pin_vec[gi]),
            .level(line_lvl[gi])
        );
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_cnt <= '0;
            deb_cnt <= '0;
        end else if (ce) begin
            div_cnt <= scan_tick ? '0 : div_cnt + 1'b1;
            deb_cnt <= deb_tick ? '0 : deb_cnt + 1'b1;
        end
    end

    // Counter stops at the matched code while the hold timer runs
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            scan_cnt <= '0;
            drive_lines <= 16'h0001;
        end else if (ce && advance) begin
            scan_cnt <= scan_cnt + 8'h01;
            drive_lines <= 16'h0001 << (scan_cnt[3:0] + 4'h1);
        end
    end

    // Retriggerable one-shot: refreshed on every scan tick that senses the key
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_cnt <= '0;
        end else if (ce) begin
            if (match) begin
                hold_cnt <= HOLD_LOAD;
            end else if (held) begin
                hold_cnt <= hold_cnt - 1'b1;
            end
        end
    end

    function automatic key_code_t remap(input key_code_t raw, input logic sh, input logic ct);
        key_code_t c;
        c = raw;
        if (sh) begin
            if (c >= 7'h61 && c <= 7'h7a) begin
                c = c ^ 7'h20;
            end else if (c >= 7'h30 && c <= 7'h3f) begin
                c = c ^ 7'h10;
            end
        end
        if (ct) begin
            c = c & 7'h1f;
        end
        return c;
    endfunction

    always_comb begin
        next_state = state;
        unique case (state)
            ST_SCAN: begin
                if (match) begin
                    next_state = ST_SETTLE;
                end
            end
            ST_SETTLE: next_state = ST_PRESENT;
            ST_PRESENT: begin
                if (!held) begin
                    next_state = ST_RELEASE;
                end
            end
            ST_RELEASE: next_state = ST_SCAN;
        endcase
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_SCAN;
            code_reg <= '0;
        end else if (ce) begin
            state <= next_state;
            if (state == ST_SCAN && match) begin
                code_reg <= remap(scan_cnt[6:0], shift_lvl, ctl_lvl);
            end else if (state == ST_RELEASE) begin
                code_reg <= '0;
            end
        end
    end

    // Code lines are plain active-high, no inversion
    assign key_code = code_reg;
    // Lockout gates only strobe and function keys; code lines still show
    assign key_code_valid_strobe = (state == ST_PRESENT) && outputs_ok;
    assign interrupt_key_line = intr_lvl && outputs_ok;
    assign repeat_key_line = rpt_lvl && outputs_ok;

    // APB slave: zero wait states, read data captured in the setup cycle
    wire logic sel_ctrl = (paddr == `KS_CTRL_OFS);
    wire logic sel_status = (paddr == `KS_STATUS_OFS);
    wire logic sel_count = (paddr == `KS_COUNT_OFS);
    wire logic addr_hit = sel_ctrl || sel_status || sel_count;
    wire logic wr_ctrl = psel && penable && pwrite && sel_ctrl && pstrb[0];
    wire logic [31:0] status_word = {19'h0, !outputs_ok, held, rpt_lvl, intr_lvl,
        key_code_valid_strobe, 1'b0, code_reg};
    wire logic [31:0] rd_mux = sel_ctrl ? {30'h0, ctrl} :
        sel_status ? status_word :
        sel_count ? {24'h0, scan_cnt} : 32'h0;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_hit;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `KS_CTRL_RESET;
            prdata <= 32'h0;
        end else if (ce) begin
            if (wr_ctrl) begin
                ctrl <= pwdata[1:0];
            end
            if (psel && !penable && !pwrite) begin
                prdata <= rd_mux;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_matched;
        ce && state == ST_SCAN && match;
    endsequence

    sequence s_settled;
        state == ST_SETTLE ##1 state == ST_PRESENT;
    endsequence

    decode_onehot_a: assert property (drive_lines == (16'h0001 << scan_cnt[3:0]))
        else $error("decoder line does not follow counter low bits");

    count_step_a: assert property (ce && advance |=> scan_cnt == $past(scan_cnt) + 8'h01)
        else $error("idle counter failed to step");

    count_freeze_a: assert property (held |=> $stable(scan_cnt))
        else $error("counter moved while hold timer ran");

    hold_refresh_a: assert property (ce && match |=> hold_cnt == HOLD_LOAD && held)
        else $error("hold timer not retriggered on match");

    strobe_settle_a: assert property (s_matched |=> s_settled)
        else $error("strobe did not follow settle cycle");

    code_stable_a: assert property (state == ST_PRESENT && $past(state) == ST_PRESENT
        |-> $stable(code_reg))
        else $error("code changed while strobe active");

    release_clear_a: assert property (ce && state == ST_RELEASE |=> code_reg == 7'h00
        && state == ST_SCAN)
        else $error("code not cleared after release");

    ctrl_remap_a: assert property (s_matched and ctl_lvl |=> code_reg[6:5] == 2'b00)
        else $error("control key did not clear upper bits");

    lock_gate_a: assert property (!lock_pin_lvl |-> !key_code_valid_strobe
        && !interrupt_key_line && !repeat_key_line)
        else $error("output active under lockout");

    sequence s_shift_lower;
        ce && state == ST_SCAN && match && shift_lvl && !ctl_lvl && scan_cnt[6:5] == 2'b11
            && scan_cnt[4:0] != 5'h00 && scan_cnt[4:0] <= 5'h1a;
    endsequence

    sequence s_hold_lapsed;
        ce && state == ST_PRESENT && !held;
    endsequence

    // Strobe may only follow a settle cycle in which the code stood still
    strobe_late_a: assert property (state == ST_PRESENT && $past(state) != ST_PRESENT
        |-> $past(state) == ST_SETTLE && $stable(code_reg))
        else $error("strobe rose before code lines settled");

    present_hold_a: assert property (ce && state == ST_PRESENT && held
        |=> state == ST_PRESENT && $stable(code_reg))
        else $error("strobe dropped while key still held");

    release_drop_a: assert property (s_hold_lapsed |=> state == ST_RELEASE
        && !key_code_valid_strobe)
        else $error("strobe stayed after hold timer ran out");

    idle_code_a: assert property (state == ST_SCAN |-> key_code == 7'h00)
        else $error("code lines active while scanning");

    count_wrap_a: assert property (ce && advance && scan_cnt == 8'hff
        |=> scan_cnt == 8'h00)
        else $error("scan counter did not wrap");

    shift_upper_a: assert property (s_shift_lower |=> code_reg[6:5] == 2'b10
        && code_reg[4:0] == $past(scan_cnt[4:0]))
        else $error("shift did not give the upper case code");

    hold_decay_a: assert property (ce && !match && held
        |=> hold_cnt == $past(hold_cnt) - 1'b1)
        else $error("hold timer did not count down");

    mux_match_a: assert property (ce && scan_en && scan_tick && sense_lvl[scan_cnt[7:4]]
        |=> held)
        else $error("sensed key did not start the hold timer");

    soft_lock_a: assert property (ctrl[`KS_CTRL_LOCK] |-> !key_code_valid_strobe
        && !interrupt_key_line && !repeat_key_line)
        else $error("output active under soft lock");

    ctrl_write_a: assert property (ce && wr_ctrl |=> ctrl == $past(pwdata[1:0]))
        else $error("control write did not land");

    count_read_a: assert property (ce && psel && !penable && !pwrite && sel_count
        |=> prdata == {24'h0, $past(scan_cnt)})
        else $error("count read returned wrong value");

endmodule // keyboard_scan_encoder

// ==== kbd_scan_map.svh ====
// Offsets, field positions, reset values and timing counts of the keyboard scan encoder.
// Assumes a 100 MHz clock and 32-bit APB with one register per aligned word.
`ifndef KBD_SCAN_MAP_SVH
`define KBD_SCAN_MAP_SVH

`define KS_CLK_MHZ 100
`define KS_SCAN_PERIOD_NS 200
`define KS_SCAN_CYC ((`KS_SCAN_PERIOD_NS * `KS_CLK_MHZ + 999) / 1000)
`define KS_HOLD_NS 1000
`define KS_HOLD_CYC ((`KS_HOLD_NS * `KS_CLK_MHZ + 999) / 1000)
`define KS_DEB_PERIOD_US 5000
`define KS_DEB_CYC (`KS_DEB_PERIOD_US * `KS_CLK_MHZ)

`define KS_CTRL_OFS 8'h00
`define KS_STATUS_OFS 8'h04
`define KS_COUNT_OFS 8'h08

`define KS_CTRL_SCAN_EN 0
`define KS_CTRL_LOCK 1
`define KS_CTRL_RESET 2'h1

`define KS_ST_CODE_LSB 0
`define KS_ST_STROBE 8
`define KS_ST_INTR 9
`define KS_ST_REPEAT 10
`define KS_ST_HELD 11
`define KS_ST_LOCKED 12

`endif

// ==== kbd_scan_pkg.sv ====
// Types shared by the keyboard scan encoder files.
// Assumes kbd_scan_map.svh for all numeric constants.
package kbd_scan_pkg;

    // Gray codes along scan -> settle -> present -> release
    typedef enum logic [1:0] {
        ST_SCAN = 2'b00,
        ST_SETTLE = 2'b01,
        ST_PRESENT = 2'b11,
        ST_RELEASE = 2'b10
    } key_state_t;

    typedef logic [6:0] key_code_t;

endpackage

// ==== key_line_filter.sv ====
// One input line: three-flop synchroniser, then a two-stage slow sampler.
// Assumes sample_tick is a one-cycle pulse on clk; tie high for no debounce.
module key_line_filter (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    // Line
    input wire logic sample_tick,
    input wire logic pin,
    output logic level
);

    logic sync1, sync2, sync3, agreed, samp0, samp1;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync1 <= 1'b0;
            sync2 <= 1'b0;
            sync3 <= 1'b0;
        end else if (ce) begin
            sync1 <= pin;
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // A change counts only once the second and third stages agree
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            agreed <= 1'b0;
        end else if (ce && sync2 == sync3) begin
            agreed <= sync3;
        end
    end

    // Two flops per key on the slow tick; output moves only on two equal samples
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            samp0 <= 1'b0;
            samp1 <= 1'b0;
            level <= 1'b0;
        end else if (ce && sample_tick) begin
            samp0 <= agreed;
            samp1 <= samp0;
            if (samp0 == samp1) begin
                level <= samp1;
            end
        end
    end

endmodule // key_line_filter

// ==== key_receiver.sv ====
// Front-end receiver model: latches one key code per strobe rise.
// Assumes code and strobe are levels, synchronous to clk.
module key_receiver (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Encoder side
    input wire logic [6:0] key_code,
    input wire logic key_code_valid_strobe,
    // Own lock, lifted by the interrupt key
    input wire logic lock_req,
    input wire logic interrupt_key_line,
    // Taken codes
    output logic [6:0] last_code,
    output logic [7:0] taken,
    output logic locked
);
    timeunit 1ns;
    timeprecision 1ns;
    logic stb_d;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stb_d <= 1'b0;
            last_code <= 7'h00;
            taken <= 8'h00;
            locked <= 1'b0;
        end else begin
            stb_d <= key_code_valid_strobe;
            // Interrupt key must always free a locked receiver
            if (interrupt_key_line) begin
                locked <= 1'b0;
            end else if (lock_req) begin
                locked <= 1'b1;
            end
            // Rising edge only, so a held key is taken once
            if (key_code_valid_strobe && !stb_d && !locked) begin
                last_code <= key_code;
                taken <= taken + 8'h01;
            end
        end
    end
endmodule // key_receiver

// ==== testbench.sv ====
// Self-checking bench for the keyboard scan encoder.
// Assumes a one-key matrix model here and key_receiver on the code lines.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rstn = 1'b0, ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, key_code_valid_strobe;
    logic interrupt_key_line, repeat_key_line;
    logic [15:0] drive_lines;
    logic [15:0] sense_lines = 16'h0;
    logic shift_key = 1'b0, control_key = 1'b0, lockout_n = 1'b1;
    logic interrupt_key_pin = 1'b0, repeat_key_pin = 1'b0, pressed = 1'b0;
    logic [7:0] pk = 8'h00;
    logic rx_lock = 1'b0, locked;
    logic [7:0] taken;
    logic [6:0] key_code, last_code;
    int errors = 0, n_tests = 0;

    always #5 clk = ~clk;
    // One key closes its crosspoint
    always @(posedge clk) begin
        sense_lines <= (pressed && drive_lines[pk[3:0]]) ? 16'h1 << pk[7:4] : 16'h0;
    end

    keyboard_scan_encoder #(.SCAN_CYC(12), .HOLD_CYC(30), .DEB_CYC(4))
        i_keyboard_scan_encoder (.clk, .rstn, .ce, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .drive_lines, .sense_lines,
        .shift_key, .control_key, .interrupt_key_pin, .repeat_key_pin, .lockout_n,
        .key_code, .key_code_valid_strobe, .interrupt_key_line, .repeat_key_line);
    key_receiver i_key_receiver (.clk, .rstn, .key_code, .key_code_valid_strobe,
        .lock_req(rx_lock), .interrupt_key_line, .last_code, .taken, .locked);

    task automatic wrap_up();
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        if (pready !== 1'b1) begin
            errors++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic sel(input int k);
        case (k)
            0: return key_code_valid_strobe;
            1: return interrupt_key_line;
            2: return repeat_key_line;
            default: return key_code !== 7'h00;
        endcase
    endfunction

    // Bounded wait; a miss ends the run
    task automatic wait_for(input int k, input logic v, input int bound);
        for (int i = 0; i < bound && sel(k) !== v; i++) @(posedge clk);
        check(sel(k), v);
        if (sel(k) !== v) wrap_up();
    endtask

    task automatic press(input logic [7:0] k, input logic [6:0] exp);
        pk <= k;
        pressed <= 1'b1;
        wait_for(0, 1'b1, 4000);
        check(key_code, exp);
        repeat (200) @(posedge clk);
        check({key_code_valid_strobe, key_code}, {1'b1, exp});
        check(last_code, exp);
        apb(1'b0, 8'h08, 32'h0);
        check(rd[7:0], k);
        apb(1'b0, 8'h04, 32'h0);
        check(rd, {20'h0, 4'h9, 1'b0, exp});
        pressed <= 1'b0;
        wait_for(0, 1'b0, 200);
        wait_for(3, 1'b0, 4);
    endtask

    task automatic t_regs();
        logic [31:0] c0;
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        check(err, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        c0 = rd;
        repeat (33) @(posedge clk);
        apb(1'b0, 8'h08, 32'h0);
        check(8'(rd[7:0] - c0[7:0]), 8'h03);
        check(drive_lines & (drive_lines - 16'h1), 16'h0);
        // Scan disabled: counter must not move
        apb(1'b1, 8'h00, 32'h0);
        apb(1'b0, 8'h08, 32'h0);
        c0 = rd;
        repeat (30) @(posedge clk);
        apb(1'b0, 8'h08, 32'h0);
        check(rd, c0);
        apb(1'b1, 8'h00, 32'h1);
        // Clock enable low freezes the decoder lines
        ce <= 1'b0;
        @(posedge clk);
        c0 = {16'h0, drive_lines};
        repeat (30) @(posedge clk);
        check(drive_lines, c0[15:0]);
        ce <= 1'b1;
    endtask

    task automatic t_mods();
        logic [7:0] keys [8] = '{8'h61, 8'h61, 8'h61, 8'h61, 8'h30, 8'h30, 8'h30, 8'h30};
        logic [6:0] exps [8] = '{7'h61, 7'h41, 7'h01, 7'h01, 7'h30, 7'h20, 7'h10, 7'h00};
        for (int i = 0; i < 8; i++) begin
            shift_key <= i[0];
            control_key <= i[1];
            press(keys[i], exps[i]);
        end
        shift_key <= 1'b0;
        control_key <= 1'b0;
        check(taken, 8'h08);
    endtask

    task automatic t_func();
        rx_lock <= 1'b1;
        @(posedge clk);
        rx_lock <= 1'b0;
        @(posedge clk);
        check(locked, 1'b1);
        interrupt_key_pin <= 1'b1;
        wait_for(1, 1'b1, 50);
        repeat (40) @(posedge clk);
        check({interrupt_key_line, key_code_valid_strobe}, 2'b10);
        check(locked, 1'b0);
        interrupt_key_pin <= 1'b0;
        wait_for(1, 1'b0, 50);
        repeat_key_pin <= 1'b1;
        wait_for(2, 1'b1, 50);
        repeat_key_pin <= 1'b0;
        wait_for(2, 1'b0, 50);
    endtask

    task automatic t_lock();
        lockout_n <= 1'b0;
        interrupt_key_pin <= 1'b1;
        pk <= 8'h41;
        pressed <= 1'b1;
        wait_for(3, 1'b1, 4000);
        repeat (40) @(posedge clk);
        check({key_code_valid_strobe, interrupt_key_line}, 2'b00);
        apb(1'b0, 8'h04, 32'h0);
        check({rd[12], rd[9], rd[8]}, 3'b110);
        apb(1'b1, 8'h00, 32'h3);
        lockout_n <= 1'b1;
        repeat (20) @(posedge clk);
        check({key_code_valid_strobe, interrupt_key_line}, 2'b00);
        apb(1'b0, 8'h00, 32'h0);
        check(rd, 32'h3);
        apb(1'b1, 8'h00, 32'h1);
        wait_for(0, 1'b1, 20);
        check({interrupt_key_line, key_code}, {1'b1, 7'h41});
        pressed <= 1'b0;
        interrupt_key_pin <= 1'b0;
        wait_for(0, 1'b0, 200);
        check(taken, 8'h09);
    endtask

    initial begin
        repeat (2) @(posedge clk);
        check({drive_lines, key_code, key_code_valid_strobe}, {16'h0001, 8'h00});
        repeat (14) @(posedge clk);
        rstn <= 1'b1;
        repeat (8) @(posedge clk);
        t_regs();
        t_mods();
        t_func();
        t_lock();
        wrap_up();
    end
endmodule // testbench
